// File: design/sfw_watchdog.sv
`timescale 1ns/1ps
module sfw_watchdog #(
  parameter int COUNT_WIDTH = sfw_pkg::COUNT_WIDTH,
  parameter int TICKS       = sfw_pkg::TIMEOUT_TICKS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Microcontroller data bus
  input  wire logic [15:0] mcu_addr,
  input  wire logic        mcu_wr_en,
  input  wire logic [7:0]  mcu_wr_data,
  input  wire logic        mcu_rd_en,
  output logic      [7:0]  mcu_rd_data,
  // USB engine
  input  wire logic        sof_pulse,
  output logic             usb_attach,
  // Reset and status
  output logic             mcu_reset,
  output logic             watchdog_running
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic reset_n;

  sfw_sync #(
    .WIDTH (1)
  ) u_reset_sync (
    .clock   (clock),
    .clear_n (resetn),
    .d       (1'b1),
    .q       (reset_n)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [4:0]                     disable_key_low_bits;
  logic                           disable_key_top_bit;
  logic                           timeout_reset_flag;
  logic                           usb_connect_bit;
  sfw_pkg::sfw_state_t            state;
  logic [sfw_pkg::PULSE_WIDTH-1:0] pulse_count;
  logic                           hit_status;
  logic                           hit_usb_control_register;
  logic                           service;
  logic                           enabled;
  logic                           advance;
  logic                           expire;
  logic [COUNT_WIDTH-1:0]         count;

  localparam logic [sfw_pkg::PULSE_WIDTH-1:0] PULSE_LAST =
    sfw_pkg::PULSE_WIDTH'(sfw_pkg::RESET_PULSE_CYCLES - 1);

  assign hit_status = (mcu_addr == sfw_pkg::WATCHDOG_CONTROL_STATUS_ADDR);
  assign hit_usb_control_register = (mcu_addr == sfw_pkg::USB_CONTROL_REGISTER_ADDR);

  assign service = mcu_wr_en && hit_status && mcu_wr_data[sfw_pkg::SERVICE_BIT_POS];

  assign enabled = !((disable_key_low_bits == sfw_pkg::KEY_LOW_DISABLE) &&
                     (disable_key_top_bit == sfw_pkg::KEY_TOP_DISABLE));

  // Ticks come only from start-of-frame, and only while attached
  assign advance = sof_pulse && usb_connect_bit && enabled && (state == sfw_pkg::SFW_RUN);

  assign watchdog_running = enabled;
  assign usb_attach       = usb_connect_bit;
  assign mcu_reset        = (state == sfw_pkg::SFW_RESETTING);

  // ----------------------------------------
  // Watchdog count
  // ----------------------------------------
  sfw_tick_counter #(
    .WIDTH (COUNT_WIDTH),
    .TICKS (TICKS)
  ) u_counter (
    .clock   (clock),
    .reset_n (reset_n),
    .restart (service || mcu_reset),
    .advance (advance),
    .count   (count),
    .expire  (expire)
  );

  // ----------------------------------------
  // Microcontroller reset pulse
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state       <= sfw_pkg::SFW_RUN;
      pulse_count <= '0;
    end else begin
      case (state)
        sfw_pkg::SFW_RUN: begin
          pulse_count <= '0;
          if (expire) begin
            state <= sfw_pkg::SFW_RESETTING;
          end
        end
        sfw_pkg::SFW_RESETTING: begin
          if (pulse_count == PULSE_LAST) begin
            state <= sfw_pkg::SFW_RUN;
          end else begin
            pulse_count <= sfw_pkg::PULSE_WIDTH'(pulse_count + 1'b1);
          end
        end
        default: begin
          state <= sfw_pkg::SFW_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Disable key
  // ----------------------------------------
  // A time-out resets the chip, so the key returns to its enabled value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      disable_key_low_bits <= sfw_pkg::KEY_LOW_RESET;
      disable_key_top_bit  <= sfw_pkg::KEY_TOP_RESET;
    end else if (expire) begin
      disable_key_low_bits <= sfw_pkg::KEY_LOW_RESET;
      disable_key_top_bit  <= sfw_pkg::KEY_TOP_RESET;
    end else if (mcu_wr_en && hit_status) begin
      disable_key_low_bits <= mcu_wr_data[sfw_pkg::KEY_LOW_MSB:sfw_pkg::KEY_LOW_LSB];
      disable_key_top_bit  <= mcu_wr_data[sfw_pkg::KEY_TOP_POS];
    end
  end

  // ----------------------------------------
  // Reset-cause flag
  // ----------------------------------------
  // Only the power-up reset or a write of 1 to bit 6 clears it; a time-out must survive its own reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timeout_reset_flag <= sfw_pkg::FLAG_RESET;
    end else if (expire) begin
      timeout_reset_flag <= 1'b1;
    end else if (mcu_wr_en && hit_status && mcu_wr_data[sfw_pkg::TIMEOUT_FLAG_POS]) begin
      timeout_reset_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // USB connect bit
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      usb_connect_bit <= sfw_pkg::CONNECT_RESET;
    end else if (expire) begin
      usb_connect_bit <= sfw_pkg::CONNECT_RESET;
    end else if (mcu_wr_en && hit_usb_control_register) begin
      usb_connect_bit <= mcu_wr_data[sfw_pkg::CONNECT_BIT_POS];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mcu_rd_data <= sfw_pkg::READ_IDLE;
    end else if (mcu_rd_en && hit_status) begin
      mcu_rd_data <= sfw_pkg::READ_IDLE;
      mcu_rd_data[sfw_pkg::KEY_TOP_POS]                      <= disable_key_top_bit;
      mcu_rd_data[sfw_pkg::TIMEOUT_FLAG_POS]                 <= timeout_reset_flag;
      mcu_rd_data[sfw_pkg::KEY_LOW_MSB:sfw_pkg::KEY_LOW_LSB] <= disable_key_low_bits;
      mcu_rd_data[sfw_pkg::SERVICE_BIT_POS]                  <= 1'b0;
    end else if (mcu_rd_en && hit_usb_control_register) begin
      mcu_rd_data <= sfw_pkg::READ_IDLE;
      mcu_rd_data[sfw_pkg::CONNECT_BIT_POS] <= usb_connect_bit;
    end else if (mcu_rd_en) begin
      mcu_rd_data <= sfw_pkg::READ_IDLE;
    end
  end

endmodule

// File: design/sfw_pkg.sv
// Summary of operation
// - After 128 unserviced one-millisecond ticks the watchdog resets the microcontroller.
// - Watchdog runs after reset and stops only with disable key 101010b.
// - The one-millisecond tick is taken from USB start-of-frame pulses.
// - Count advances only while the USB connect bit is set, else holds.
// - Writing 1 to bit 0 restarts the count; 0 is ignored; reads 0.
// - The watchdog count is a seven-bit counter stepped by the tick.
// - Disabled only when bits 5:1 are 10101b and bit 7 is 0.
// - Bit 6 reads 0 after power-up, 1 after a watchdog time-out reset.
// - Writing 1 to bit 6 clears the reset-cause flag; 0 leaves it.
// - Reset loads key top bit with 1 and key low bits with zero.
// - USB connect bit attaches the device to the bus; clear after reset.
package sfw_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] WATCHDOG_CONTROL_STATUS_ADDR = 16'hFF93;
  localparam logic [15:0] USB_CONTROL_REGISTER_ADDR    = 16'hFFFC;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SERVICE_BIT_POS  = 0;
  localparam int KEY_LOW_LSB      = 1;
  localparam int KEY_LOW_MSB      = 5;
  localparam int TIMEOUT_FLAG_POS = 6;
  localparam int KEY_TOP_POS      = 7;
  localparam int CONNECT_BIT_POS  = 7;

  // ----------------------------------------
  // Reset values and disable key
  // ----------------------------------------
  localparam logic [4:0] KEY_LOW_RESET   = 5'h00;
  localparam logic       KEY_TOP_RESET   = 1'h1;
  localparam logic       FLAG_RESET      = 1'h0;
  localparam logic       CONNECT_RESET   = 1'h0;
  localparam logic [4:0] KEY_LOW_DISABLE = 5'h15;
  localparam logic       KEY_TOP_DISABLE = 1'h0;
  localparam logic [7:0] READ_IDLE       = 8'h00;

  // ----------------------------------------
  // Counting and timing
  // ----------------------------------------
  localparam int COUNT_WIDTH     = 7;
  localparam int TIMEOUT_TICKS   = 128;
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int RESET_PULSE_NS  = 100;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int PULSE_WIDTH     = 5;

  typedef enum logic {
    SFW_RUN,
    SFW_RESETTING
  } sfw_state_t;

endpackage

// File: design/sfw_sync.sv
`timescale 1ns/1ps
module sfw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             clear_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge clear_n) begin
    if (!clear_n) begin
      stage <= '0;
      q     <= '0;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

// File: design/sfw_tick_counter.sv
`timescale 1ns/1ps
module sfw_tick_counter #(
  parameter int WIDTH = sfw_pkg::COUNT_WIDTH,
  parameter int TICKS = sfw_pkg::TIMEOUT_TICKS
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Control
  input  wire logic             restart,
  input  wire logic             advance,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  expire
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(TICKS - 1);

  assign expire = advance && !restart && (count == LAST);

  // Restart beats a tick landing in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (advance) begin
      count <= WIDTH'(count + 1'b1);
    end
  end

endmodule

// File: tb/sfw_watchdog_sva.sv
`timescale 1ns/1ps
module sfw_watchdog_sva #(
  parameter int TICKS = 128
) (
  // Watched ports
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [15:0] mcu_addr,
  input wire logic        mcu_wr_en,
  input wire logic [7:0]  mcu_wr_data,
  input wire logic        mcu_rd_en,
  input wire logic [7:0]  mcu_rd_data,
  input wire logic        sof_pulse,
  input wire logic        usb_attach,
  input wire logic        mcu_reset,
  input wire logic        watchdog_running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic fw_wr;
  logic key_hit;
  assign fw_wr   = mcu_wr_en && mcu_addr == 16'hFF93;
  assign key_hit = (mcu_wr_data & 8'hBE) == 8'h2A;
  sequence pulse_s; mcu_reset ##19 mcu_reset ##1 !mcu_reset; endsequence
  sequence key_s; fw_wr && !sof_pulse && key_hit; endsequence
  pulse_len_a: assert property ($rose(mcu_reset) |-> pulse_s)
    else $error("Reset pulse length wrong");
  attach_drop_a: assert property ($rose(mcu_reset) |-> !usb_attach)
    else $error("Attach kept over time-out");
  svc_read_a: assert property (mcu_rd_en && mcu_addr == 16'hFF93 |=> !mcu_rd_data[0])
    else $error("Service bit read as 1");
  unmapped_rd_a: assert property (mcu_rd_en && mcu_addr != 16'hFF93 && mcu_addr != 16'hFFFC |=> !mcu_rd_data) 
    else $error("Unmapped read not zero");
  key_stop_a: assert property (key_s |=> !watchdog_running)
    else $error("Key did not stop timer");
  key_run_a: assert property (fw_wr && !key_hit |=> watchdog_running)
    else $error("Timer stopped by wrong key");
  connect_hold_a: assert property (!usb_attach && !mcu_wr_en |=> !$rose(mcu_reset))
    else $error("Time-out while not connected");
  sof_only_a: assert property (!sof_pulse |=> !$rose(mcu_reset))
    else $error("Time-out without a frame tick");
  svc_win_a: assert property (fw_wr && mcu_wr_data[0] |=> !$rose(mcu_reset))
    else $error("Time-out despite service");
endmodule
bind sfw_watchdog sfw_watchdog_sva #(.TICKS(TICKS)) sva_i (.clock(clock), .resetn(resetn), .mcu_addr(mcu_addr),
  .mcu_wr_en(mcu_wr_en), .mcu_wr_data(mcu_wr_data), .mcu_rd_en(mcu_rd_en), .mcu_rd_data(mcu_rd_data),
  .sof_pulse(sof_pulse), .usb_attach(usb_attach), .mcu_reset(mcu_reset), .watchdog_running(watchdog_running));

// File: tb/sfw_fw_model.sv
`timescale 1ns/1ps
module sfw_fw_model (
  // Clock
  input  wire logic        clock,
  // Register bus
  output logic      [15:0] mcu_addr,
  output logic             mcu_wr_en,
  output logic      [7:0]  mcu_wr_data,
  output logic             mcu_rd_en,
  input  wire logic [7:0]  mcu_rd_data
);
  initial begin
    mcu_addr = 16'h0000;
    mcu_wr_en = 1'b0;
    mcu_wr_data = 8'h00;
    mcu_rd_en = 1'b0;
  end
  // One strobe cycle, then idle lines show the inverse so stale values never look valid
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    mcu_addr = a;
    mcu_wr_data = d;
    mcu_wr_en = w;
    mcu_rd_en = !w;
    @(posedge clock);
    #1;
    mcu_wr_en = 1'b0;
    mcu_rd_en = 1'b0;
    mcu_addr = ~a;
    mcu_wr_data = ~d;
    q = mcu_rd_data;
  endtask
endmodule

// File: tb/tb_sof_ticked_watchdog.sv
`timescale 1ns/1ps
module tb_sof_ticked_watchdog;
  localparam int TK = 4;
  logic clock = 0, resetn = 0, sof_pulse = 0, usb_attach, mcu_reset, watchdog_running, mcu_wr_en, mcu_rd_en;
  logic [15:0] mcu_addr;
  logic [7:0] mcu_wr_data, mcu_rd_data, q;
  logic top = 1, flag = 0, con = 0;
  logic [4:0] low = 0;
  int cnt = 0, err_count = 0, cmp_count = 0, seed = 32'h1b9da700;
  sfw_watchdog #(.TICKS(TK)) dut (.clock(clock), .resetn(resetn), .mcu_addr(mcu_addr), .mcu_wr_en(mcu_wr_en),
    .mcu_wr_data(mcu_wr_data), .mcu_rd_en(mcu_rd_en), .mcu_rd_data(mcu_rd_data), .sof_pulse(sof_pulse),
    .usb_attach(usb_attach), .mcu_reset(mcu_reset), .watchdog_running(watchdog_running));
  sfw_fw_model fw (.clock(clock), .mcu_addr(mcu_addr), .mcu_wr_en(mcu_wr_en), .mcu_wr_data(mcu_wr_data),
    .mcu_rd_en(mcu_rd_en), .mcu_rd_data(mcu_rd_data));
  initial forever #2.5 clock = ~clock;
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic run_m();
    return !(top == 1'b0 && low == 5'h15);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    fw.acc(1'b1, a, d, q);
    if (a == 16'hFF93) begin
      top = d[7];
      low = d[5:1];
      if (d[6]) flag = 0;
      if (d[0]) cnt = 0;
    end
    if (a == 16'hFFFC) con = d[7];
    chk(watchdog_running, run_m());
  endtask
  task automatic rd(input logic [15:0] a);
    fw.acc(1'b0, a, 8'h00, q);
    chk(q, a == 16'hFF93 ? {top, flag, low, 1'b0} : a == 16'hFFFC ? {con, 7'h00} : 8'h00);
  endtask
  // Model steps the count per frame tick; random gaps vary tick spacing
  task automatic tick(input int n);
    repeat (n) begin
      repeat ($random(seed) & 3) @(posedge clock);
      @(posedge clock);
      #1 sof_pulse = 1;
      @(posedge clock);
      #1 sof_pulse = 0;
      if (con && run_m()) cnt++;
      chk(mcu_reset, cnt == TK);
      if (cnt == TK) begin
        // A time-out sets the cause flag and puts key and connect back to their reset values
        flag = 1'b1;
        top  = 1'b1;
        low  = 5'h00;
        con  = 1'b0;
        cnt  = 0;
        repeat (20) @(posedge clock);
        #1 chk(mcu_reset, 1'b0);
      end
      chk(usb_attach, con);
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1 resetn = 1;
    repeat (3) @(posedge clock);
    rd(16'hFF93);
    rd(16'hFFFC);
    rd(16'hFF90);
    tick(TK + 1);
    wr(16'hFFFC, 8'h80);
    tick(TK - 1);
    rd(16'hFF93);
    wr(16'hFF93, 8'h80);
    tick(1);
    rd(16'hFF93);
    wr(16'hFF93, 8'h00);
    rd(16'hFF93);
    wr(16'hFF93, 8'hC0);
    rd(16'hFF93);
    wr(16'hFFFC, 8'h80);
    tick(TK - 1);
    wr(16'hFF93, 8'(8'h81 | ($random(seed) & 8'h3E)));
    tick(TK - 1);
    wr(16'hFF93, 8'h2A);
    tick(TK + 1);
    for (int i = 1; i < 8; i++) wr(16'hFF93, 8'(8'h2A ^ (8'h01 << i)));
    tick(1);
    complete_run();
  end
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
endmodule
